/* src/input_cond_pkg.sv */
// Purpose: shared constants for the digital input conditioning block
// Assumes: 250 MHz clock, 32-bit classic Wishbone register port
// Notes: byte offsets are word aligned; route table occupies its own window
package input_cond_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_SF_EN = 8'h04;
   localparam logic [7:0] OFS_INVERT = 8'h08;
   localparam logic [7:0] OFS_FORCE_EN = 8'h0C;
   localparam logic [7:0] OFS_FORCE_VAL = 8'h10;
   localparam logic [7:0] OFS_RAW = 8'h14;
   localparam logic [7:0] OFS_THRESH = 8'h18;
   localparam logic [7:0] OFS_DIFF = 8'h1C;
   localparam logic [7:0] OFS_ROUTE_EN = 8'h20;
   // route table: entry k (status bit k) at ROUTE_BASE + 4*k
   localparam logic [7:0] ROUTE_BASE = 8'h80;
   // status word layout
   localparam int LEVEL_LSB = 16;
   localparam int SF_NEG_LIMIT = 0;
   localparam int SF_POS_LIMIT = 1;
   localparam int SF_HOME = 2;
   localparam int SF_COUNT = 3;
   // route source codes
   localparam logic [6:0] SRC_ZERO = 7'h00;
   localparam logic [6:0] SRC_PHYS_FIRST = 7'h01;
   localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
   localparam logic [6:0] SRC_ENC_A = 7'h44;
   localparam logic [6:0] SRC_ENC_B = 7'h45;
   localparam logic [6:0] SRC_ENC_IDX = 7'h46;
   localparam int SRC_INV_BIT = 7;
   // reset values
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [7:0] ROUTE_RESET = 8'h00;
   // sampling period
   localparam int CLK_PERIOD_NS = 4;
   localparam int SAMPLE_PERIOD_NS = 1000000;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
endpackage

/* src/digital_input_conditioning.sv */
// Purpose: sample, condition and route six digital inputs into a 32-bit status word
// Assumes: pins asynchronous to clk_i; Wishbone master follows classic single cycles
// Notes: threshold settings only drive outputs to the analog front end; the differential setting also pairs the sampled pins
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

// Function
// - special-function results occupy status bits 0 to 15
// - plain input levels occupy status bits 16 to 31
// - input n level sits at bit 15+n regardless of special-function enable
// - inputs sampled once per millisecond; shorter pulses may be missed
// - input 1 negative limit, input 2 positive limit, input 3 home
// - enable register bits 0..2 gate special functions, never level bits
// - invert bit selects normally closed, except clock and direction uses
// - force enable substitutes force value bit for the sampled pin
// - raw register shows sampled value before inversion, forcing, routing
// - range bit drives threshold select: 0 for 5 V, 1 for 24 V
// - one differential setting turns six single inputs into three pairs
// - input 1: bit 0 is negative limit, bit 16 conditioned level
// - writing 1 to routing enable selects table-driven status bits
// - entering routing mode preloads table so behaviour stays unchanged
// - table entry n drives status bit n
// - codes: 00 zero, 01-10 physical inputs, 44-46 encoder signals
// - bit 7 of code inverts source; 80 gives constant one
module digital_input_conditioning #(
   parameter int NUM_IN = 6,
   parameter int SAMPLE_CYCLES = input_cond_pkg::SAMPLE_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // pins
   input wire logic [NUM_IN-1:0] in_pin_i,
   input wire logic enc_a_i,
   input wire logic enc_b_i,
   input wire logic enc_idx_i,
   input wire logic clk_dir_mode_i,
   // front end control and result
   output logic [NUM_IN-1:0] threshold_sel_o,
   output logic diff_mode_o,
   output logic [31:0] input_status_o
);
   localparam int NPIN = NUM_IN + 3;
   localparam int CW = $clog2(SAMPLE_CYCLES + 1);

   // synchronizer: third stage confirms the second before a change counts
   logic [NPIN-1:0] sync1;
   logic [NPIN-1:0] sync2;
   logic [NPIN-1:0] sync3;
   logic [NPIN-1:0] pin_q;
   wire [NPIN-1:0] pin_async = {enc_idx_i, enc_b_i, enc_a_i, in_pin_i};
   wire [NPIN-1:0] pin_agree = ~(sync2 ^ sync3);
   wire [NPIN-1:0] next_pin_q = (pin_agree & sync3) | (~pin_agree & pin_q);

   always_ff @(posedge clk_i) begin
      sync1 <= pin_async;
      sync2 <= sync1;
      sync3 <= sync2;
      if (rst_i) begin
         pin_q <= '0;
      end else begin
         pin_q <= next_pin_q;
      end
   end

   // registers
   logic [31:0] sf_en;
   logic [31:0] invert;
   logic [31:0] force_en;
   logic [31:0] force_val;
   logic [31:0] thresh;
   logic diff_mode;
   logic route_en;
   logic [7:0] route_tbl [0:31];
   logic [NUM_IN-1:0] raw;
   logic [CW-1:0] tick_cnt;
   logic [31:0] status;

   // millisecond tick
   wire tick = (tick_cnt == CW'(SAMPLE_CYCLES - 1));
   wire [CW-1:0] next_tick_cnt = tick ? '0 : tick_cnt + CW'(1);

   // differential pairs: input k from pin 2k+1 (plus) against pin 2k (minus)
   logic [NUM_IN-1:0] diff_val;
   always_comb begin
      diff_val = '0;
      for (int k = 0; k < NUM_IN / 2; k++) begin
         diff_val[k] = pin_q[2*k+1] & ~pin_q[2*k];
      end
   end
   wire [NUM_IN-1:0] pin_level = diff_mode ? diff_val : pin_q[NUM_IN-1:0];
   wire [2:0] enc = pin_q[NPIN-1:NUM_IN];

   // conditioning chain: raw, then force, then inversion
   wire [NUM_IN-1:0] forced = (force_en[NUM_IN-1:0] & force_val[NUM_IN-1:0]) |
      (~force_en[NUM_IN-1:0] & raw);
   wire [NUM_IN-1:0] cond = forced ^ invert[NUM_IN-1:0];
   wire [15:0] phys16 = 16'(forced);

   // clock and direction uses ignore the inversion bit
   wire pos_src = clk_dir_mode_i ? forced[1] : cond[1];
   wire home_src = clk_dir_mode_i ? forced[2] : cond[2];
   wire [2:0] sf_res = sf_en[2:0] & {home_src, pos_src, cond[0]};
   wire [31:0] normal_status = {16'(cond), 13'h0000, sf_res};

   function automatic logic route_pick(input logic [7:0] code, input logic [15:0] phys,
                                       input logic [2:0] encs);
      logic [6:0] c;
      logic hit;
      logic val;
      c = code[6:0];
      hit = 1'b1;
      val = 1'b0;
      if (c == input_cond_pkg::SRC_ZERO) begin
         val = 1'b0;
      end else if (c >= input_cond_pkg::SRC_PHYS_FIRST && c <= input_cond_pkg::SRC_PHYS_LAST) begin
         val = phys[4'(c - 7'h01)];
      end else if (c == input_cond_pkg::SRC_ENC_A) begin
         val = encs[0];
      end else if (c == input_cond_pkg::SRC_ENC_B) begin
         val = encs[1];
      end else if (c == input_cond_pkg::SRC_ENC_IDX) begin
         val = encs[2];
      end else begin
         hit = 1'b0;
      end
      return hit & (val ^ code[input_cond_pkg::SRC_INV_BIT]);
   endfunction

   logic [31:0] routed_status;
   always_comb begin
      routed_status = '0;
      for (int b = 0; b < 32; b++) begin
         routed_status[b] = route_pick(route_tbl[b], phys16, enc);
      end
   end
   wire [31:0] next_status = route_en ? routed_status : normal_status;

   // wishbone decode
   wire req = cyc_i & stb_i & ~ack_o;
   wire wr = req & we_i;
   wire in_table = (adr_i >= input_cond_pkg::ROUTE_BASE);
   wire [4:0] tbl_idx = adr_i[6:2];
   wire hit_sf = (adr_i == input_cond_pkg::OFS_SF_EN);
   wire hit_inv = (adr_i == input_cond_pkg::OFS_INVERT);
   wire hit_fen = (adr_i == input_cond_pkg::OFS_FORCE_EN);
   wire hit_fval = (adr_i == input_cond_pkg::OFS_FORCE_VAL);
   wire hit_thr = (adr_i == input_cond_pkg::OFS_THRESH);
   wire hit_diff = (adr_i == input_cond_pkg::OFS_DIFF);
   wire hit_ren = (adr_i == input_cond_pkg::OFS_ROUTE_EN);
   wire [31:0] bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   wire route_rise = wr && hit_ren && sel_i[0] && dat_i[0] && !route_en;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [31:0] m);
      return (old & ~m) | (d & m);
   endfunction

   logic [31:0] rd_data;
   always_comb begin
      rd_data = '0;
      if (in_table) begin
         rd_data = {24'h000000, route_tbl[tbl_idx]};
      end else if (adr_i == input_cond_pkg::OFS_STATUS) begin
         rd_data = status;
      end else if (hit_sf) begin
         rd_data = sf_en;
      end else if (hit_inv) begin
         rd_data = invert;
      end else if (hit_fen) begin
         rd_data = force_en;
      end else if (hit_fval) begin
         rd_data = force_val;
      end else if (adr_i == input_cond_pkg::OFS_RAW) begin
         rd_data = 32'(raw);
      end else if (hit_thr) begin
         rd_data = thresh;
      end else if (hit_diff) begin
         rd_data = {31'h0000_0000, diff_mode};
      end else if (hit_ren) begin
         rd_data = {31'h0000_0000, route_en};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
         tick_cnt <= '0;
         raw <= '0;
         status <= '0;
      end else begin
         ack_o <= req;
         dat_o <= req ? rd_data : dat_o;
         tick_cnt <= next_tick_cnt;
         raw <= tick ? pin_level : raw;
         status <= next_status;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sf_en <= input_cond_pkg::CFG_RESET;
         invert <= input_cond_pkg::CFG_RESET;
         force_en <= input_cond_pkg::CFG_RESET;
         force_val <= input_cond_pkg::CFG_RESET;
         thresh <= input_cond_pkg::CFG_RESET;
         diff_mode <= 1'b0;
         route_en <= 1'b0;
      end else if (wr && !in_table) begin
         if (hit_sf) sf_en <= merge(sf_en, dat_i, bmask);
         if (hit_inv) invert <= merge(invert, dat_i, bmask);
         if (hit_fen) force_en <= merge(force_en, dat_i, bmask);
         if (hit_fval) force_val <= merge(force_val, dat_i, bmask);
         if (hit_thr) thresh <= merge(thresh, dat_i, bmask);
         if (hit_diff && sel_i[0]) diff_mode <= dat_i[0];
         if (hit_ren && sel_i[0]) route_en <= dat_i[0];
      end
   end

   // preload mirrors normal mode; level entries track the live invert bits at entry.
   // a later change of enable or invert is not reflected, hence no repeated toggling.
   always_ff @(posedge clk_i) begin
      for (int b = 0; b < 32; b++) begin
         if (rst_i) begin
            route_tbl[b] <= input_cond_pkg::ROUTE_RESET;
         end else if (route_rise) begin
            if (b >= input_cond_pkg::LEVEL_LSB && b < input_cond_pkg::LEVEL_LSB + NUM_IN) begin
               route_tbl[b] <= {invert[b-16], 7'(b - 15)};
            end else if (b < input_cond_pkg::SF_COUNT && sf_en[b]) begin
               route_tbl[b] <= {invert[b] & !(clk_dir_mode_i && b != 0), 7'(b + 1)};
            end else begin
               route_tbl[b] <= input_cond_pkg::ROUTE_RESET;
            end
         end else if (wr && in_table && tbl_idx == 5'(b) && sel_i[0]) begin
            route_tbl[b] <= dat_i[7:0];
         end
      end
   end

   assign threshold_sel_o = thresh[NUM_IN-1:0];
   assign diff_mode_o = diff_mode;
   assign input_status_o = status;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   level_map_a: assert property (!route_en |=> route_en || status[16 +: NUM_IN] == $past(cond))
      else $error("level bits do not follow conditioned inputs");
   upper_zero_a: assert property (!route_en && !$past(route_en) |-> status[31:16+NUM_IN] == '0)
      else $error("unused level bits not zero");
   special_gate_a: assert property (!route_en && !sf_en[0] |=> !status[0] || $past(route_en) || route_en)
      else $error("negative limit active while disabled");
   sf_band_a: assert property (!route_en && !$past(route_en) |-> status[15:3] == '0)
      else $error("special band has stray bits");
   raw_hold_a: assert property (!tick |=> $stable(raw))
      else $error("raw changed between sample ticks");
   force_sub_a: assert property (force_en[0] |-> forced[0] == force_val[0])
      else $error("force value not substituted");
   thresh_write_a: assert property (wr && hit_thr && sel_i[0] |=> threshold_sel_o[0] == $past(dat_i[0]))
      else $error("threshold select not updated");
   preload_a: assert property (route_rise |=> route_tbl[16] == {$past(invert[0]), 7'h01})
      else $error("route table not preloaded for input 1");
   route_zero_a: assert property (route_en && route_tbl[3] == 8'hA0 |=> !status[3] || !$past(route_en))
      else $error("unlisted code did not give zero");
   route_one_a: assert property (route_en && route_tbl[4] == 8'h80 ##1 route_en |-> status[4])
      else $error("code 80 did not give constant one");
   ack_pulse_a: assert property (req |=> ack_o ##1 !ack_o)
      else $error("ack not a single cycle answer");

   // bus side
   ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without a request");
   rd_latch_a: assert property (req && !we_i |=> dat_o == $past(rd_data))
      else $error("read data not latched");
   dat_hold_a: assert property (!req |=> $stable(dat_o))
      else $error("read data moved without a request");
   unmapped_rd_a: assert property (req && !we_i && adr_i == 8'h40 |=> dat_o == '0)
      else $error("unmapped read not zero");
   raw_rd_a: assert property (req && !we_i && adr_i == input_cond_pkg::OFS_RAW |=> dat_o == 32'($past(raw)))
      else $error("raw read wrong");
   status_rd_a: assert property (req && !we_i && adr_i == input_cond_pkg::OFS_STATUS |=> dat_o == $past(status))
      else $error("status read wrong");
   table_rd_a: assert property (req && !we_i && in_table |=> dat_o[31:8] == '0)
      else $error("table read upper bits not zero");
   invert_write_a: assert property (wr && hit_inv && sel_i == 4'hF |=> invert == $past(dat_i))
      else $error("invert register not written");
   diff_write_a: assert property (wr && hit_diff && sel_i[0] |=> diff_mode_o == $past(dat_i[0]))
      else $error("differential select not written");
   thresh_hold_a: assert property (!(wr && hit_thr) |=> $stable(threshold_sel_o))
      else $error("threshold select moved without a write");
   route_en_hold_a: assert property (!(wr && hit_ren) |=> $stable(route_en))
      else $error("routing enable moved without a write");

   // sampling path
   sync_confirm_a: assert property (pin_agree[0] |=> pin_q[0] == $past(sync3[0]))
      else $error("agreed pin level not taken");
   sync_hold_a: assert property (!pin_agree[0] |=> $stable(pin_q[0]))
      else $error("pin level moved without agreement");
   tick_wrap_a: assert property (tick |=> tick_cnt == '0)
      else $error("sample counter did not wrap");
   tick_count_a: assert property (!tick |=> tick_cnt == $past(tick_cnt) + CW'(1))
      else $error("sample counter did not advance");
   raw_sample_a: assert property (tick |=> raw == $past(pin_level))
      else $error("raw not sampled on tick");
   diff_pair_a: assert property (diff_mode |-> pin_level[0] == (pin_q[1] && !pin_q[0]))
      else $error("differential pair wrong");
   diff_upper_a: assert property (diff_mode |-> pin_level[NUM_IN-1:NUM_IN/2] == '0)
      else $error("unused differential inputs not zero");
   single_level_a: assert property (!diff_mode |-> pin_level == pin_q[NUM_IN-1:0])
      else $error("single-ended level wrong");
   invert_low_a: assert property (!force_en[0] |-> cond[0] == (raw[0] ^ invert[0]))
      else $error("inversion of input 1 wrong");
   invert_top_a: assert property (!force_en[NUM_IN-1] |-> cond[NUM_IN-1] == (raw[NUM_IN-1] ^ invert[NUM_IN-1]))
      else $error("inversion of last input wrong");
   force_off_a: assert property (!force_en[1] |-> forced[1] == raw[1])
      else $error("unforced input not raw");
   force_top_a: assert property (force_en[NUM_IN-1] |-> forced[NUM_IN-1] == force_val[NUM_IN-1])
      else $error("last input not forced");

   // normal mode status
   level_top_a: assert property (!route_en |=> status[16+NUM_IN-1] == $past(cond[NUM_IN-1]))
      else $error("last level bit wrong");
   sf_neg_a: assert property (!route_en && sf_en[0] |=> status[0] == $past(cond[0]))
      else $error("negative limit bit wrong");
   sf_pos_a: assert property (!route_en && sf_en[1] && !clk_dir_mode_i |=> status[1] == $past(cond[1]))
      else $error("positive limit bit wrong");
   sf_home_a: assert property (!route_en && sf_en[2] && !clk_dir_mode_i |=> status[2] == $past(cond[2]))
      else $error("home bit wrong");
   sf_pos_cd_a: assert property (!route_en && sf_en[1] && clk_dir_mode_i |=> status[1] == $past(forced[1]))
      else $error("direction bit inverted");
   sf_home_cd_a: assert property (!route_en && sf_en[2] && clk_dir_mode_i |=> status[2] == $past(forced[2]))
      else $error("clock bit inverted");
   sf_off_pos_a: assert property (!route_en && !sf_en[1] |=> !status[1])
      else $error("positive limit active while disabled");
   sf_off_home_a: assert property (!route_en && !sf_en[2] |=> !status[2])
      else $error("home active while disabled");

   // routing mode status
   route_sel_a: assert property (route_en |=> status == $past(routed_status))
      else $error("routed status not selected");
   route_const_a: assert property (route_en && route_tbl[20][6:0] == 7'h00 |=> status[20] == $past(route_tbl[20][7]))
      else $error("constant source wrong");
   route_phys_a: assert property (route_en && route_tbl[17] == 8'h02 |=> status[17] == $past(forced[1]))
      else $error("physical source wrong");
   route_inv_a: assert property (route_en && route_tbl[16] == 8'h81 |=> status[16] == !$past(forced[0]))
      else $error("inverted physical source wrong");
   route_enc_a: assert property (route_en && route_tbl[18] == 8'h44 |=> status[18] == $past(enc[0]))
      else $error("encoder A source wrong");
   route_enc_b_a: assert property (route_en && route_tbl[19] == 8'hC5 |=> status[19] == !$past(enc[1]))
      else $error("inverted encoder B source wrong");
   route_idx_a: assert property (route_en && route_tbl[22] == 8'hC6 |=> status[22] == !$past(enc[2]))
      else $error("inverted index source wrong");
   route_unlisted_a: assert property (route_en && route_tbl[20] == 8'h47 |=> !status[20])
      else $error("unlisted code not zero");
   route_phys_hi_a: assert property (route_en && route_tbl[22] == 8'h10 |=> !status[22])
      else $error("absent input not zero");
   route_low_a: assert property (route_en && route_tbl[0] == 8'h80 |=> status[0])
      else $error("constant one on bit 0 missing");

   // preload on entry to routing mode
   preload_sf_a: assert property (route_rise && sf_en[0] |=> route_tbl[0][6:0] == 7'h01)
      else $error("negative limit entry not preloaded");
   preload_off_a: assert property (route_rise && !sf_en[1] |=> route_tbl[1] == 8'h00)
      else $error("disabled entry not cleared");
   preload_cd_a: assert property (route_rise && sf_en[2] && clk_dir_mode_i |=> !route_tbl[2][7])
      else $error("clock entry preloaded inverted");
   preload_level_a: assert property (route_rise |=> route_tbl[16+NUM_IN-1][6:0] == 7'(NUM_IN))
      else $error("last level entry not preloaded");
   preload_band_a: assert property (route_rise |=> route_tbl[31] == 8'h00)
      else $error("unused entry not cleared");
endmodule
`default_nettype wire

/* dv/pin_source_model.sv */
// Purpose: switch, sensor and encoder levels seen by the input block
// Assumes: the bench requests levels; this model puts them on the pins
// Notes: levels move only on a clock edge, then hold for many sample periods
`timescale 1ns/1ns
`default_nettype none
module pin_source_model (
   // clock
   input wire logic clk_i,
   // levels asked for by the bench
   input wire logic [5:0] want_pins_i,
   input wire logic [2:0] want_enc_i,
   // pins toward the block
   output var logic [5:0] in_pin_o = 6'h00,
   output var logic enc_a_o = 1'b0,
   output var logic enc_b_o = 1'b0,
   output var logic enc_idx_o = 1'b0
);
   // a pulse shorter than one sample period could be missed, so none is made
   always @(posedge clk_i) begin
      in_pin_o <= want_pins_i;
      {enc_idx_o, enc_b_o, enc_a_o} <= want_enc_i;
   end
endmodule
`default_nettype wire

/* dv/digital_input_conditioning_tb_top.sv */
// Purpose: register-level test of the digital input conditioning block
// Assumes: sample period shortened to 8 cycles
// Notes: every level change is given 24 cycles to reach the status word
`timescale 1ns/1ns
`default_nettype none
module digital_input_conditioning_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, clk_dir = 1'b0;
   logic [3:0] sel = 4'hF;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, dat_o, status_o, rd;
   logic ack_o, diff_o, enc_a, enc_b, enc_idx;
   logic [5:0] thr_o, pins, want_pins = 6'h00;
   logic [2:0] want_enc = 3'h0;
   logic [7:0] codes [2][7] = '{'{8'h81, 8'h02, 8'h44, 8'hC5, 8'h47, 8'h85, 8'hC6},
                                '{8'h00, 8'h90, 8'hC4, 8'h45, 8'h46, 8'h07, 8'h10}};
   logic [2:0] encs [2] = '{3'b001, 3'b110};
   logic [31:0] route_exp [2] = '{32'h006E_0011, 32'h001E_0011};
   int n_fail = 0, samples_checked = 0, cycles = 0;
   always #2 clk_i = ~clk_i;
   digital_input_conditioning #(.NUM_IN(6), .SAMPLE_CYCLES(8)) digital_input_conditioning_i (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .in_pin_i(pins), .enc_a_i(enc_a),
      .enc_b_i(enc_b), .enc_idx_i(enc_idx), .clk_dir_mode_i(clk_dir), .threshold_sel_o(thr_o),
      .diff_mode_o(diff_o), .input_status_o(status_o));
   pin_source_model pin_source_model_i (.clk_i(clk_i), .want_pins_i(want_pins), .want_enc_i(want_enc),
      .in_pin_o(pins), .enc_a_o(enc_a), .enc_b_o(enc_b), .enc_idx_o(enc_idx));
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n == 20) n_fail++;
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      wb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask
   task automatic st(input logic [31:0] exp);
      repeat (24) @(posedge clk_i);
      check("status port", status_o, exp);
      expect_rd(input_cond_pkg::OFS_STATUS, exp, "status reg");
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 4; a <= 32; a += 4) begin
         expect_rd(8'(a), input_cond_pkg::CFG_RESET, "reset value");
      end
      expect_rd(input_cond_pkg::ROUTE_BASE, {24'h0, input_cond_pkg::ROUTE_RESET}, "route reset");
      wb(1'b1, input_cond_pkg::OFS_THRESH, 32'h0000_002A);
      check("threshold", {26'h0, thr_o}, 32'h0000_002A);
      wb(1'b1, input_cond_pkg::OFS_DIFF, 32'h0000_0001);
      want_pins <= 6'h0E;
      st(32'h0001_0000);
      check("diff out", {31'h0, diff_o}, 32'h0000_0001);
      wb(1'b1, input_cond_pkg::OFS_DIFF, 32'h0);
      wb(1'b1, input_cond_pkg::OFS_SF_EN, 32'h0000_0007);
      want_pins <= 6'h05;
      st(32'h0005_0005);
      expect_rd(input_cond_pkg::OFS_RAW, 32'h0000_0005, "raw");
      clk_dir <= 1'b1;
      wb(1'b1, input_cond_pkg::OFS_INVERT, 32'h0000_003F);
      st(32'h003A_0004);
      clk_dir <= 1'b0;
      wb(1'b1, input_cond_pkg::OFS_INVERT, 32'h0);
      wb(1'b1, input_cond_pkg::OFS_FORCE_EN, 32'h0000_0002);
      wb(1'b1, input_cond_pkg::OFS_FORCE_VAL, 32'h0000_0002);
      st(32'h0007_0007);
      expect_rd(input_cond_pkg::OFS_RAW, 32'h0000_0005, "raw forced");
      wb(1'b1, input_cond_pkg::OFS_SF_EN, 32'h0000_0001);
      st(32'h0007_0001);
      wb(1'b1, 8'h40, 32'hFFFF_FFFF);
      expect_rd(8'h40, 32'h0, "unmapped");
      wb(1'b1, input_cond_pkg::OFS_ROUTE_EN, 32'h0000_0001);
      st(32'h0007_0001);
      expect_rd(input_cond_pkg::ROUTE_BASE + 8'h40, 32'h0000_0001, "preload");
      wb(1'b1, input_cond_pkg::ROUTE_BASE, 32'hFFFF_FF80);
      expect_rd(input_cond_pkg::ROUTE_BASE, 32'h0000_0080, "route entry");
      wb(1'b1, input_cond_pkg::ROUTE_BASE + 8'h0C, 32'h0000_00A0);
      wb(1'b1, input_cond_pkg::ROUTE_BASE + 8'h10, 32'h0000_0080);
      // entries for status bits 16 to 22, two passes with opposite encoder levels
      for (int p = 0; p < 2; p++) begin
         want_enc <= encs[p];
         for (int k = 0; k < 7; k++) begin
            wb(1'b1, input_cond_pkg::ROUTE_BASE + 8'(4 * (16 + k)), {24'h0, codes[p][k]});
         end
         st(route_exp[p]);
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire
